// >>> rtl/acrb_device.sv
// acrb_device: converter end: configuration bank and sampling core.
// assumes sample_clk_i and ain_i are synchronous to clk_i, and that
// clk_i runs at least four times faster than sample_clk_i.
//
// Functional notes
// - host sets companion bit with offset correction
// - host writes zero to reserved bits
// - host sets performance flags per recommended combination; acrb_host passes the user's flags through, only masked
// - override bit picks pin or register boost
// - swing field: 00 off, 11 on, others unused
// - bits 3,2 power down channels D, C
// - bits 1,0 power down channels B, A
// - all channels sampled together on falling edge
// - samples appear ten sample clocks later
// - double data rate lanes, twos complement code
// - eleven-bit words per channel
// - all registers reset to zero
// - register disable turns boost off only while the override bit is set
`timescale 1ns/1ps
`default_nettype none
module acrb_device #(
  parameter int NUM_CH   = acrb_pkg::NUM_CH,
  parameter int SAMPLE_W = acrb_pkg::SAMPLE_W,
  parameter int LATENCY  = acrb_pkg::LATENCY_CYC,
  localparam int LANE_W  = (SAMPLE_W + 1) / 2
) (
  // clock, reset, enable
  input  wire logic                               clk_i,
  input  wire logic                               rstn_i,
  input  wire logic                               ce_i,
  // register link
  acrb_if.device                                  bus,
  // converter side
  input  wire logic                               sample_clk_i,
  input  wire logic [NUM_CH-1:0][SAMPLE_W-1:0]    ain_i,
  input  wire logic                               boost_control_pin_i,
  output logic      [NUM_CH-1:0][SAMPLE_W-1:0]    data_o,
  output logic                                    data_valid_o,
  output logic      [NUM_CH-1:0][LANE_W-1:0]      lane_o,
  output logic                                    lane_phase_o,
  output logic                                    boost_active_o,
  output logic      [NUM_CH-1:0]                  ch_powered_down_o,
  output logic                                    output_swing_prog_enable_o,
  output logic                                    offset_corr_companion_bit_o,
  output logic      [15:0]                        perf_mode_o
);
  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    logic [7:0]                              offs;
    logic [7:0]                              perf_a;
    logic [7:0]                              perf_b;
    logic [7:0]                              perf_c;
    logic [7:0]                              perf_d;
    logic [7:0]                              perf_e;
    logic [7:0]                              ovrd;
    logic [7:0]                              perf_f;
    logic [7:0]                              swing;
    logic [7:0]                              perf_g;
    logic [7:0]                              pdn;
    logic [7:0]                              boost_dis;
    logic [7:0]                              rdata;
    logic                                    rvalid;
    logic                                    sclk;
    logic [LATENCY-1:0][NUM_CH-1:0][SAMPLE_W-1:0] pipe;
    logic [LATENCY-1:0]                      fill;
    logic [NUM_CH-1:0][SAMPLE_W-1:0]         data;
    logic                                    valid;
    logic [NUM_CH-1:0][LANE_W-1:0]           lane;
    logic                                    phase;
    logic                                    boost;
    logic                                    swing_on;
  } acrb_dev_state_type;

  acrb_dev_state_type state_q;
  acrb_dev_state_type state_d;

  // ***********************************************************
  // lane split: even bits on one phase, odd bits on the other
  // ***********************************************************
  logic [NUM_CH-1:0][LANE_W-1:0] even_bits;
  logic [NUM_CH-1:0][LANE_W-1:0] odd_bits;
  logic [NUM_CH-1:0][SAMPLE_W-1:0] twos;

  genvar gc;
  genvar gb;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
      // input code is offset binary; flipping the msb gives twos complement
      assign twos[gc] = {~ain_i[gc][SAMPLE_W-1], ain_i[gc][SAMPLE_W-2:0]};
      for (gb = 0; gb < LANE_W; gb++) begin : g_bit
        assign even_bits[gc][gb] = state_q.pipe[LATENCY-1][gc][2*gb];
        if (2*gb + 1 < SAMPLE_W) begin : g_odd
          assign odd_bits[gc][gb] = state_q.data[gc][2*gb+1];
        end else begin : g_pad
          assign odd_bits[gc][gb] = 1'b0;
        end
      end
    end
  endgenerate

  // ***********************************************************
  // next state
  // ***********************************************************
  logic       fall;
  logic       rise;
  logic [7:0] wmask;
  logic [7:0] wval;
  logic [3:0] pd_map;

  always_comb begin
    state_d = state_q;
    fall    = state_q.sclk & ~sample_clk_i;
    rise    = ~state_q.sclk & sample_clk_i;
    wmask   = acrb_pkg::acrb_mask(bus.addr);
    wval    = bus.wdata & wmask; // reserved bits are not stored
    state_d.sclk   = sample_clk_i;
    state_d.rvalid = 1'b0;

    // register write port
    if (bus.wr_en) begin
      case (bus.addr)
        acrb_pkg::OFF_OFFS_COMP: state_d.offs      = wval;
        acrb_pkg::OFF_PERF_A:    state_d.perf_a    = wval;
        acrb_pkg::OFF_PERF_B:    state_d.perf_b    = wval;
        acrb_pkg::OFF_PERF_C:    state_d.perf_c    = wval;
        acrb_pkg::OFF_PERF_D:    state_d.perf_d    = wval;
        acrb_pkg::OFF_PERF_E:    state_d.perf_e    = wval;
        acrb_pkg::OFF_OVRD:      state_d.ovrd      = wval;
        acrb_pkg::OFF_PERF_F:    state_d.perf_f    = wval;
        acrb_pkg::OFF_SWING:     state_d.swing     = wval;
        acrb_pkg::OFF_PERF_G:    state_d.perf_g    = wval;
        acrb_pkg::OFF_PDN:       state_d.pdn       = wval;
        acrb_pkg::OFF_BOOST_DIS: state_d.boost_dis = wval;
        default: ;
      endcase
    end

    // register read port; unmapped addresses read zero
    if (bus.rd_en) begin
      state_d.rvalid = 1'b1;
      case (bus.addr)
        acrb_pkg::OFF_OFFS_COMP: state_d.rdata = state_q.offs;
        acrb_pkg::OFF_PERF_A:    state_d.rdata = state_q.perf_a;
        acrb_pkg::OFF_PERF_B:    state_d.rdata = state_q.perf_b;
        acrb_pkg::OFF_PERF_C:    state_d.rdata = state_q.perf_c;
        acrb_pkg::OFF_PERF_D:    state_d.rdata = state_q.perf_d;
        acrb_pkg::OFF_PERF_E:    state_d.rdata = state_q.perf_e;
        acrb_pkg::OFF_OVRD:      state_d.rdata = state_q.ovrd;
        acrb_pkg::OFF_PERF_F:    state_d.rdata = state_q.perf_f;
        acrb_pkg::OFF_SWING:     state_d.rdata = state_q.swing;
        acrb_pkg::OFF_PERF_G:    state_d.rdata = state_q.perf_g;
        acrb_pkg::OFF_PDN:       state_d.rdata = state_q.pdn;
        acrb_pkg::OFF_BOOST_DIS: state_d.rdata = state_q.boost_dis;
        default:                 state_d.rdata = 8'h00;
      endcase
    end

    // boost source: pin, or the register disable bit when overridden
    if (state_q.ovrd[acrb_pkg::BIT_OVRD]) begin
      state_d.boost = ~state_q.boost_dis[acrb_pkg::BIT_BOOST_DIS];
    end else begin
      state_d.boost = boost_control_pin_i;
    end
    // registered so the enable leaves on a flop; unused codes read as off
    state_d.swing_on = (state_q.swing[acrb_pkg::SWING_LSB +: 2] == acrb_pkg::SWING_ON);

    // channel order in vectors is A, B, C, D from bit 0
    pd_map[0] = state_q.pdn[acrb_pkg::POWERDOWN_FIRST_CHANNEL];
    pd_map[1] = state_q.pdn[acrb_pkg::POWERDOWN_SECOND_CHANNEL];
    pd_map[2] = state_q.pdn[acrb_pkg::POWERDOWN_THIRD_CHANNEL];
    pd_map[3] = state_q.pdn[acrb_pkg::POWERDOWN_FOURTH_CHANNEL];

    // one falling edge samples every channel at once and steps the pipe
    if (fall) begin
      state_d.pipe[0] = twos;
      state_d.fill[0] = 1'b1;
      for (int s = 1; s < LATENCY; s++) begin
        state_d.pipe[s] = state_q.pipe[s-1];
        state_d.fill[s] = state_q.fill[s-1];
      end
      state_d.data  = state_q.pipe[LATENCY-1];
      state_d.valid = state_q.fill[LATENCY-1];
      state_d.lane  = even_bits;
      state_d.phase = 1'b0;
    end else if (rise) begin
      state_d.lane  = odd_bits;
      state_d.phase = 1'b1;
    end

    // a powered-down channel drives a quiet zero code
    for (int c = 0; c < NUM_CH; c++) begin
      if (c < 4 && pd_map[c % 4]) begin
        state_d.data[c] = '0;
        state_d.lane[c] = '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q <= '0;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign bus.rdata                   = state_q.rdata;
  assign bus.rvalid                  = state_q.rvalid;
  assign data_o                      = state_q.data;
  assign data_valid_o                = state_q.valid;
  assign lane_o                      = state_q.lane;
  assign lane_phase_o                = state_q.phase;
  assign boost_active_o              = state_q.boost;
  assign ch_powered_down_o           = NUM_CH'(state_q.pdn[3:0]);
  assign output_swing_prog_enable_o  = state_q.swing_on;
  assign offset_corr_companion_bit_o = state_q.offs[acrb_pkg::BIT_OFFS_COMP];
  assign perf_mode_o = {state_q.perf_a[7], state_q.perf_b[7], state_q.perf_c[7],
                        state_q.perf_d[3:2], state_q.perf_e[5:4],
                        state_q.perf_f[5:3], state_q.swing[5],
                        state_q.perf_g[6], state_q.perf_g[1], 3'h0};
endmodule : acrb_device
`default_nettype wire

// >>> rtl/acrb_pkg.sv
// acrb_pkg: shared constants of the converter configuration bank.
// assumes 8-bit register addresses and 8-bit register data.
package acrb_pkg;
  // ***********************************************************
  // register offsets
  // ***********************************************************
  localparam logic [7:0] OFF_OFFS_COMP = 8'hCF;
  localparam logic [7:0] OFF_PERF_A    = 8'hD4;
  localparam logic [7:0] OFF_PERF_B    = 8'hD5;
  localparam logic [7:0] OFF_PERF_C    = 8'hD6;
  localparam logic [7:0] OFF_PERF_D    = 8'hD7;
  localparam logic [7:0] OFF_PERF_E    = 8'hDB;
  localparam logic [7:0] OFF_OVRD      = 8'hEA;
  localparam logic [7:0] OFF_PERF_F    = 8'hF0;
  localparam logic [7:0] OFF_SWING     = 8'hF1;
  localparam logic [7:0] OFF_PERF_G    = 8'hF5;
  localparam logic [7:0] OFF_PDN       = 8'hFE;
  localparam logic [7:0] OFF_BOOST_DIS = 8'h44;
  // ***********************************************************
  // writable bits per register, reset value, field positions
  // ***********************************************************
  localparam logic [7:0] MSK_OFFS_COMP = 8'h08;
  localparam logic [7:0] MSK_PERF_ABC  = 8'h80;
  localparam logic [7:0] MSK_PERF_D    = 8'h0C;
  localparam logic [7:0] MSK_PERF_E    = 8'h30;
  localparam logic [7:0] MSK_OVRD      = 8'h80;
  localparam logic [7:0] MSK_PERF_F    = 8'h38;
  localparam logic [7:0] MSK_SWING     = 8'h23;
  localparam logic [7:0] MSK_PERF_G    = 8'h42;
  localparam logic [7:0] MSK_PDN       = 8'h0F;
  localparam logic [7:0] MSK_BOOST_DIS = 8'h01;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam int         BIT_OFFS_COMP = 3;
  localparam int         BIT_OVRD      = 7;
  localparam int         BIT_BOOST_DIS = 0;
  localparam int         SWING_LSB     = 0;
  localparam logic [1:0] SWING_OFF     = 2'h0;
  localparam logic [1:0] SWING_ON      = 2'h3;
  localparam int         POWERDOWN_FIRST_CHANNEL      = 0;
  localparam int         POWERDOWN_SECOND_CHANNEL      = 1;
  localparam int         POWERDOWN_THIRD_CHANNEL      = 2;
  localparam int         POWERDOWN_FOURTH_CHANNEL      = 3;
  // ***********************************************************
  // converter core
  // ***********************************************************
  localparam int NUM_CH      = 4;
  localparam int SAMPLE_W    = 11;
  localparam int LATENCY_CYC = 10;

  // writable bits of an address; zero marks an unmapped address
  function automatic logic [7:0] acrb_mask(input logic [7:0] a);
    case (a)
      OFF_OFFS_COMP: acrb_mask = MSK_OFFS_COMP;
      OFF_PERF_A:    acrb_mask = MSK_PERF_ABC;
      OFF_PERF_B:    acrb_mask = MSK_PERF_ABC;
      OFF_PERF_C:    acrb_mask = MSK_PERF_ABC;
      OFF_PERF_D:    acrb_mask = MSK_PERF_D;
      OFF_PERF_E:    acrb_mask = MSK_PERF_E;
      OFF_OVRD:      acrb_mask = MSK_OVRD;
      OFF_PERF_F:    acrb_mask = MSK_PERF_F;
      OFF_SWING:     acrb_mask = MSK_SWING;
      OFF_PERF_G:    acrb_mask = MSK_PERF_G;
      OFF_PDN:       acrb_mask = MSK_PDN;
      OFF_BOOST_DIS: acrb_mask = MSK_BOOST_DIS;
      default:       acrb_mask = 8'h00;
    endcase
  endfunction : acrb_mask
endpackage : acrb_pkg

// >>> rtl/acrb_if.sv
// acrb_if: register link between host controller and converter bank.
// assumes both ends share clk_i; strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface acrb_if;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  modport device (input wr_en, rd_en, addr, wdata, output rdata, rvalid);
  modport host   (output wr_en, rd_en, addr, wdata, input rdata, rvalid);
endinterface : acrb_if
`default_nettype wire

// >>> rtl/acrb_host.sv
// acrb_host: host controller end that writes and reads the bank.
// assumes one user command at a time, taken while cmd_ready_o is high.
`timescale 1ns/1ps
`default_nettype none
module acrb_host (
  // clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       ce_i,
  // user command port
  input  wire logic       cmd_valid_i,
  input  wire logic       cmd_write_i,
  input  wire logic [7:0] cmd_addr_i,
  input  wire logic [7:0] cmd_data_i,
  input  wire logic       offset_correction_select_i,
  output logic            cmd_ready_o,
  output logic            rsp_valid_o,
  output logic      [7:0] rsp_data_o,
  output logic            cmd_fixed_o,
  // register link
  acrb_if.host            bus
);
  // ***********************************************************
  // state
  // ***********************************************************
  typedef enum logic [2:0] {
    HS_IDLE  = 3'b001,
    HS_ISSUE = 3'b010,
    HS_WAIT  = 3'b100
  } acrb_hstate_type;

  typedef struct packed {
    acrb_hstate_type fsm;
    logic            wr;
    logic            rd;
    logic [7:0]      addr;
    logic [7:0]      wdata;
    logic            rsp_valid;
    logic [7:0]      rsp_data;
    logic            fixed;
  } acrb_host_state_type;

  acrb_host_state_type state_q;
  acrb_host_state_type state_d;
  logic [7:0]          clean;

  always_comb begin
    state_d           = state_q;
    state_d.wr        = 1'b0;
    state_d.rd        = 1'b0;
    state_d.rsp_valid = 1'b0;
    // only documented bits leave the host; reserved ones go out zero
    clean = cmd_data_i & acrb_pkg::acrb_mask(cmd_addr_i);
    if (cmd_addr_i == acrb_pkg::OFF_OFFS_COMP && offset_correction_select_i) begin
      clean[acrb_pkg::BIT_OFFS_COMP] = 1'b1;
    end
    if (cmd_addr_i == acrb_pkg::OFF_SWING) begin
      // unused swing codes are replaced by the off code
      if (clean[acrb_pkg::SWING_LSB +: 2] != acrb_pkg::SWING_ON) begin
        clean[acrb_pkg::SWING_LSB +: 2] = acrb_pkg::SWING_OFF;
      end
    end
    case (state_q.fsm)
      HS_IDLE: begin
        if (cmd_valid_i) begin
          state_d.addr  = cmd_addr_i;
          state_d.wdata = cmd_write_i ? clean : 8'h00;
          state_d.wr    = cmd_write_i;
          state_d.rd    = ~cmd_write_i;
          state_d.fixed = cmd_write_i && (clean != cmd_data_i);
          state_d.fsm   = HS_ISSUE;
        end
      end
      HS_ISSUE: begin
        state_d.fsm = state_q.rd ? HS_WAIT : HS_IDLE;
      end
      HS_WAIT: begin
        if (bus.rvalid) begin
          state_d.rsp_valid = 1'b1;
          state_d.rsp_data  = bus.rdata;
          state_d.fsm       = HS_IDLE;
        end
      end
      default: begin
        state_d.fsm = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q     <= '0;
      state_q.fsm <= HS_IDLE;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign bus.wr_en   = state_q.wr;
  assign bus.rd_en   = state_q.rd;
  assign bus.addr    = state_q.addr;
  assign bus.wdata   = state_q.wdata;
  assign cmd_ready_o = (state_q.fsm == HS_IDLE);
  assign rsp_valid_o = state_q.rsp_valid;
  assign rsp_data_o  = state_q.rsp_data;
  assign cmd_fixed_o = state_q.fixed;
endmodule : acrb_host
`default_nettype wire

// >>> bench/acrb_checker.sv
// acrb_checker: concurrent checks on the register link between the two ends.
// assumes it is instantiated beside the link that joins host and device.
`timescale 1ns/1ps
`default_nettype none
module acrb_checker (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rstn_i,
  // register link
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid
);
  typedef struct packed {
    logic [7:0] pdn;
    logic [7:0] ovrd;
    logic [7:0] comp;
  } acrb_shadow_type;
  acrb_shadow_type shadow_q;
  acrb_shadow_type shadow_d;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ************************************************************
  // shadow of what the host stored, so read answers can be judged
  // ************************************************************
  always_comb begin
    shadow_d = shadow_q;
    if (wr_en && addr == acrb_pkg::OFF_PDN) shadow_d.pdn = wdata;
    if (wr_en && addr == acrb_pkg::OFF_OVRD) shadow_d.ovrd = wdata;
    if (wr_en && addr == acrb_pkg::OFF_OFFS_COMP) shadow_d.comp = wdata;
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) shadow_q <= '0;
    else shadow_q <= shadow_d;
  end
  // ************************************************************
  // assertions
  // ************************************************************
  read_answer_a: assert property (rd_en |=> rvalid)
    else $error("read strobe got no answer");
  answer_cause_a: assert property (rvalid |-> $past(rd_en))
    else $error("read answer without a read");
  rd_reserved_a: assert property (rvalid |-> (rdata & ~acrb_pkg::acrb_mask($past(addr))) == 8'h00)
    else $error("reserved bits read back nonzero");
  wr_reserved_a: assert property (wr_en |-> (wdata & ~acrb_pkg::acrb_mask(addr)) == 8'h00)
    else $error("host wrote a reserved bit");
  swing_code_a: assert property (wr_en && addr == acrb_pkg::OFF_SWING |-> wdata[1] == wdata[0])
    else $error("host wrote an unused swing code");
  pdn_readback_a: assert property (rvalid && $past(addr) == acrb_pkg::OFF_PDN |-> rdata == shadow_q.pdn)
    else $error("power down register read back wrong");
  ovrd_readback_a: assert property (rvalid && $past(addr) == acrb_pkg::OFF_OVRD |-> rdata == shadow_q.ovrd)
    else $error("override register read back wrong");
  comp_readback_a: assert property (rvalid && $past(addr) == acrb_pkg::OFF_OFFS_COMP |-> rdata == shadow_q.comp)
    else $error("companion register read back wrong");
endmodule : acrb_checker
`default_nettype wire

// >>> bench/tb_adc_config_register_bank.sv
// tb_adc_config_register_bank: host and device joined over the link, user sides driven.
// assumes the package, link, design ends and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_config_register_bank;
  localparam logic [7:0] ADR [12] = '{acrb_pkg::OFF_OFFS_COMP, acrb_pkg::OFF_PERF_A,
    acrb_pkg::OFF_PERF_B, acrb_pkg::OFF_PERF_C, acrb_pkg::OFF_PERF_D, acrb_pkg::OFF_PERF_E,
    acrb_pkg::OFF_OVRD, acrb_pkg::OFF_PERF_F, acrb_pkg::OFF_SWING, acrb_pkg::OFF_PERF_G,
    acrb_pkg::OFF_PDN, acrb_pkg::OFF_BOOST_DIS};
  localparam logic [7:0] MSK [12] = '{8'h08, 8'h80, 8'h80, 8'h80, 8'h0C, 8'h30, 8'h80,
    8'h38, 8'h23, 8'h42, 8'h0F, 8'h01};
  logic             clk_i, rstn_i, cmd_valid, cmd_write, sel, sclk, pin;
  logic [7:0]       cmd_addr, cmd_data, rsp_data, r, d, e;
  logic             cmd_ready, rsp_valid, fixed, dvalid, boost, swing_en, comp;
  logic [3:0]       pdn, e_pdn;
  logic [3:0][10:0] ain, dout, es;
  logic [15:0]      lfsr;
  logic [1:0]       e_sw;
  logic             e_comp;
  int               i, n, miscompares, n_tests;
  logic [43:0]      q [$];
  logic [43:0]      last;
  logic [3:0][5:0]  lane;
  logic [15:0]      perf;
  logic [7:0]       rv [12];
  logic             lphase, ce;
  acrb_if link ();
  acrb_host acrb_host_i (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .cmd_valid_i(cmd_valid),
    .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
    .offset_correction_select_i(sel), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data), .cmd_fixed_o(fixed), .bus(link));
  acrb_device acrb_device_i (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .bus(link),
    .sample_clk_i(sclk), .ain_i(ain), .boost_control_pin_i(pin), .data_o(dout),
    .data_valid_o(dvalid), .lane_o(lane), .lane_phase_o(lphase), .boost_active_o(boost),
    .ch_powered_down_o(pdn), .output_swing_prog_enable_o(swing_en),
    .offset_corr_companion_bit_o(comp), .perf_mode_o(perf));
  acrb_checker acrb_checker_i (.clk_i(clk_i), .rstn_i(rstn_i), .wr_en(link.wr_en),
    .rd_en(link.rd_en), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
    .rvalid(link.rvalid));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd
  function automatic logic [7:0] expv(input logic [7:0] a, input logic [7:0] v, input logic s);
    logic [7:0] o;
    o = 8'h00;
    for (int j = 0; j < 12; j++) if (ADR[j] == a) o = v & MSK[j];
    if (a == acrb_pkg::OFF_OFFS_COMP && s) o[3] = 1'b1;
    if (a == acrb_pkg::OFF_SWING && o[1] != o[0]) o[1:0] = 2'h0;
    return o;
  endfunction : expv
  // lane halves of four 11-bit words: even bits, or odd bits with a zero pad on top
  function automatic logic [23:0] lanes(input logic [43:0] s, input logic odd);
    logic [3:0][5:0] o;
    o = '0;
    for (int c = 0; c < 4; c++)
      for (int b = 0; b < 6; b++)
        if (2 * b + int'(odd) < 11) o[c][b] = s[11 * c + 2 * b + int'(odd)];
    return o;
  endfunction : lanes
  task automatic chk(input string nm, input logic [43:0] ex, input logic [43:0] g);
    n_tests++;
    if (g !== ex) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, ex, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge clk_i);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_data <= v;
    #1;
    while (cmd_ready !== 1'b1) begin
      if (++k > 20) chk("command ready", 44'h1, 44'(cmd_ready));
      if (k > 20) tally_and_finish();
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    cmd_valid <= 1'b0;
    if (w) repeat (3) @(posedge clk_i);
    else begin
      do begin
        @(posedge clk_i);
        #1;
        if (++k > 40) chk("read response", 44'h1, 44'(rsp_valid));
        if (k > 40) tally_and_finish();
      end while (rsp_valid !== 1'b1);
      r = rsp_data;
    end
  endtask : cmd
  // a write then its read back, with the shadowed outputs compared too
  task automatic wr_chk(input logic [7:0] a, input logic [7:0] v);
    // expectation after the write, once the select level is settled
    cmd(1'b1, a, v);
    e = expv(a, v, sel);
    for (int j = 0; j < 12; j++) if (ADR[j] == a) rv[j] = e;
    if (a == acrb_pkg::OFF_PDN) e_pdn = e[3:0];
    if (a == acrb_pkg::OFF_SWING) e_sw = e[1:0];
    if (a == acrb_pkg::OFF_OFFS_COMP) e_comp = e[3];
    chk("data altered", 44'(e != v), 44'(fixed));
    cmd(1'b0, a, 8'h00);
    chk("read back", 44'(e), 44'(r));
    chk("power down", 44'(e_pdn), 44'(pdn));
    chk("swing enable", 44'(e_sw == 2'h3), 44'(swing_en));
    chk("companion bit", 44'(e_comp), 44'(comp));
    chk("perf flags", 44'({rv[1][7], rv[2][7], rv[3][7], rv[4][3:2], rv[5][5:4],
      rv[7][5:3], rv[8][5], rv[9][6], rv[9][1], 3'h0}), 44'(perf));
  endtask : wr_chk
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    lfsr = 16'h1616;
    rstn_i = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 8'h00;
    cmd_data = 8'h00;
    sel = 1'b0;
    sclk = 1'b0;
    pin = 1'b0;
    ain = '0;
    e_pdn = 4'h0;
    e_sw = 2'h0;
    e_comp = 1'b0;
    rv = '{default: 8'h00};
    ce = 1'b1;
    miscompares = 0;
    n_tests = 0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (i = 0; i < 12; i++) begin
      cmd(1'b0, ADR[i], 8'h00);
      chk("reset value", 44'h0, 44'(r));
    end
    chk("power down at reset", 44'h0, 44'(pdn));
    cmd(1'b0, 8'h00, 8'h00);
    chk("unmapped read", 44'h0, 44'(r));
    for (n = 0; n < 36; n++) begin
      d = 8'(rnd());
      @(posedge clk_i);
      sel <= d[7] ^ d[2];
      wr_chk(ADR[n % 12], 8'(rnd()));
    end
    // every swing code and every single power-down bit
    for (n = 0; n < 4; n++) begin
      wr_chk(acrb_pkg::OFF_SWING, 8'(n));
      wr_chk(acrb_pkg::OFF_PDN, 8'(1 << n));
    end
    // pin versus register boost control, all eight combinations
    for (n = 0; n < 8; n++) begin
      pin <= n[0];
      cmd(1'b1, acrb_pkg::OFF_OVRD, {n[2], 7'h00});
      cmd(1'b1, acrb_pkg::OFF_BOOST_DIS, {7'h00, n[1]});
      @(posedge clk_i);
      #1;
      chk("boost", 44'(n[2] ? !n[1] : n[0]), 44'(boost));
    end
    // pin control with the enable low: boost must hold its last value
    cmd(1'b1, acrb_pkg::OFF_OVRD, 8'h00);
    ce <= 1'b0;
    pin <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("boost frozen", 44'h1, 44'(boost));
    @(posedge clk_i);
    ce <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk("boost", 44'h0, 44'(boost));
    wr_chk(acrb_pkg::OFF_PDN, 8'h05);
    // sample clock two cycles high, two low; one fall event per period
    for (n = 0; n < 30; n++) begin
      @(posedge clk_i);
      sclk <= 1'b1;
      @(posedge clk_i);
      #1;
      if (n > 10) chk("odd lane", 44'({lanes(last, 1'b1), 1'b1}), 44'({lane, lphase}));
      @(posedge clk_i);
      sclk <= 1'b0;
      for (i = 0; i < 4; i++) begin
        es[i] = 11'(rnd());
        ain[i] <= es[i];
        es[i] = e_pdn[i] ? 11'h000 : {~es[i][10], es[i][9:0]};
      end
      q.push_back(es);
      @(posedge clk_i);
      #1;
      if (q.size() == 10) chk("valid early", 44'h0, 44'(dvalid));
      if (q.size() > 10) begin
        last = q.pop_front();
        chk("valid", 44'h1, 44'(dvalid));
        chk("sample", last, 44'(dout));
        chk("even lane", 44'({lanes(last, 1'b0), 1'b0}), 44'({lane, lphase}));
      end
    end
    tally_and_finish();
  end
endmodule : tb_adc_config_register_bank
`default_nettype wire
